// [common/flaca_params.svh]
`ifndef FLACA_PARAMS_SVH
`define FLACA_PARAMS_SVH

// converter geometry
`define FLACA_THERMO_W 256
`define FLACA_RES_W 9
`define FLACA_DATA_W 8
`define FLACA_OVR_CODE 9'h1ff

// timing, figures in ns and derived cycle counts at the core clock
`define FLACA_CLK_NS 10
`define FLACA_SAMPLE_MAX_NS 500
`define FLACA_SAMPLE_MAX_CYC (`FLACA_SAMPLE_MAX_NS / `FLACA_CLK_NS)
`define FLACA_SMP_W 6
`define FLACA_VALID_NS 65
`define FLACA_VALID_CYC (`FLACA_VALID_NS / `FLACA_CLK_NS)
`define FLACA_DLY_W 3

// register map, byte addresses
`define FLACA_ADDR_W 12
`define FLACA_REG_CTRL 12'h000
`define FLACA_REG_STATUS 12'h004
`define FLACA_REG_RESULT 12'h008
`define FLACA_REG_COUNT 12'h00c

// field positions and reset values
`define FLACA_CTRL_WATCH 0
`define FLACA_CTRL_WATCH_RST 1'b1
`define FLACA_STAT_OVERRUN 0
`define FLACA_STAT_FRESH 1
`define FLACA_STAT_SAMPLING 2
`define FLACA_CNT_W 16

`endif

// [common/flaca_pkg.sv]
`include "flaca_params.svh"

package flaca_pkg;

    // which half of the conversion cycle the comparators are in
    typedef enum logic {
        PH_BALANCE,
        PH_SAMPLE
    } flaca_phase_e;

    // apb request as seen by the slave
    typedef struct packed {
        logic sel;
        logic en;
        logic wr;
        logic [`FLACA_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } flaca_apb_s;

    // three-state pads, value plus enable
    typedef struct packed {
        logic [`FLACA_DATA_W-1:0] data;
        logic [`FLACA_DATA_W-1:0] data_oe;
        logic ovr;
        logic ovr_oe;
    } flaca_pads_s;

    // whole state of the converter control
    typedef struct packed {
        logic clk_m;
        logic clk_s;
        logic phase_m;
        logic phase_s;
        logic en_low_m;
        logic en_low_s;
        logic en_high_m;
        logic en_high_s;
        logic [`FLACA_THERMO_W-1:0] cmp_m;
        logic [`FLACA_THERMO_W-1:0] cmp_s;
        flaca_phase_e phase;
        logic [`FLACA_THERMO_W-1:0] row1;
        logic [`FLACA_THERMO_W-1:0] row2;
        logic [`FLACA_RES_W-1:0] out_reg;
        logic [`FLACA_RES_W-1:0] pin_val;
        logic [`FLACA_DLY_W-1:0] dly;
        logic dly_run;
        logic [`FLACA_SMP_W-1:0] smp_cnt;
        logic watch_en;
        logic overrun;
        logic fresh;
        logic [`FLACA_CNT_W-1:0] conv_cnt;
        logic [31:0] rdata;
        logic slverr;
    } flaca_state_s;

endpackage

// [hw/flaca_decode.sv]
`include "flaca_params.svh"

module flaca_decode #(
    parameter int THERMO_W = `FLACA_THERMO_W,
    parameter int RES_W = `FLACA_RES_W
) (
    input wire logic [THERMO_W-1:0] thermo_i,
    output logic [RES_W-1:0] code_o
);

    // ones count instead of edge search, so a bubble costs one lsb, not a wild code
    function automatic logic [RES_W-1:0] count_ones(input logic [THERMO_W-2:0] v);
        logic [RES_W-1:0] sum;
        sum = '0;
        for (int i = 0; i < THERMO_W - 1; i++) begin
            sum = sum + RES_W'(v[i]);
        end
        return sum;
    endfunction

    // top comparator is the over-range one and forces the full count
    always_comb begin
        if (thermo_i[THERMO_W-1]) begin
            code_o = `FLACA_OVR_CODE;
        end else begin
            code_o = count_ones(thermo_i[THERMO_W-2:0]);
        end
    end

endmodule

// [hw/flaca_conv.sv]
// Function
// - Each period of the conversion clock is one conversion: one balance half and one sample half.
// - With the polarity select high, balance happens while the clock is high and sampling while it is low.
// - The polarity select complements the incoming clock, so toggling it swaps the two halves.
// - With the polarity select low, a rising clock edge starts sampling and the first latch row tracks the comparators throughout.
// - With the polarity select low, the falling edge freezes all 256 comparator results in the first row and starts balancing.
// - At the end of balancing the first row is copied into the second row.
// - The decoded result is loaded into the output register at the next end of sampling and shows on the pins after the valid delay.
// - A result appears only after a second edge of the same kind as the one that ended its sample.
// - The output register holds eight data bits and the over-range flag, each behind a three-state driver.
// - The active-low enable high floats the eight data bits only; the flag stays driven while the high enable is high.
// - The active-high enable low floats the eight data bits and the flag.
// - Over-range sets the flag and all eight data bits, a count of 511.
`include "flaca_params.svh"

module flaca_conv (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [`FLACA_ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic CONV_CLK_I,
    input wire logic PHASE_SEL_I,
    input wire logic DATA_ENABLE_LOW_B_I,
    input wire logic ALL_ENABLE_HIGH_I,
    input wire logic [`FLACA_THERMO_W-1:0] CMP_I,
    output logic [`FLACA_DATA_W-1:0] SAMPLE_DATA_BITS_O,
    output logic [`FLACA_DATA_W-1:0] SAMPLE_DATA_BITS_OE_O,
    output logic OVER_RANGE_FLAG_O,
    output logic OVER_RANGE_FLAG_OE_O
);

    flaca_pkg::flaca_state_s st_ff;
    flaca_pkg::flaca_state_s nxt_st;
    flaca_pkg::flaca_apb_s apb;
    flaca_pkg::flaca_pads_s pads;
    flaca_pkg::flaca_phase_e cur_phase;
    logic [`FLACA_RES_W-1:0] dec_code;
    logic smp_start;
    logic smp_end;
    logic apb_setup;
    logic apb_wr;

    // address decode, shared by error answer and write path; the read mux has its own case
    function automatic logic reg_hit(input logic [`FLACA_ADDR_W-1:0] a);
        return (a == `FLACA_REG_CTRL) || (a == `FLACA_REG_STATUS) ||
               (a == `FLACA_REG_RESULT) || (a == `FLACA_REG_COUNT);
    endfunction

    function automatic logic [31:0] read_word(input logic [`FLACA_ADDR_W-1:0] a,
                                              input flaca_pkg::flaca_state_s s);
        logic [31:0] w;
        w = '0;
        case (a)
            `FLACA_REG_CTRL: begin
                w[`FLACA_CTRL_WATCH] = s.watch_en;
            end
            `FLACA_REG_STATUS: begin
                w[`FLACA_STAT_OVERRUN] = s.overrun;
                w[`FLACA_STAT_FRESH] = s.fresh;
                w[`FLACA_STAT_SAMPLING] = (s.phase == flaca_pkg::PH_SAMPLE);
            end
            `FLACA_REG_RESULT: begin
                w[`FLACA_RES_W-1:0] = s.out_reg;
            end
            `FLACA_REG_COUNT: begin
                w[`FLACA_CNT_W-1:0] = s.conv_cnt;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // bundle the bus so the process reads one carrier
    assign apb.sel = PSEL_I;
    assign apb.en = PENABLE_I;
    assign apb.wr = PWRITE_I;
    assign apb.addr = PADDR_I;
    assign apb.wdata = PWDATA_I;
    assign apb.strb = PSTRB_I;
    assign apb_setup = apb.sel && !apb.en;
    assign apb_wr = apb.sel && apb.en && apb.wr && reg_hit(apb.addr);

    // polarity select is an xor on the clock, the whole two-phase story follows from it
    assign cur_phase = (st_ff.clk_s ^ st_ff.phase_s) ? flaca_pkg::PH_SAMPLE
                                                       : flaca_pkg::PH_BALANCE;
    assign smp_start = (cur_phase == flaca_pkg::PH_SAMPLE) &&
                       (st_ff.phase == flaca_pkg::PH_BALANCE);
    assign smp_end = (cur_phase == flaca_pkg::PH_BALANCE) &&
                     (st_ff.phase == flaca_pkg::PH_SAMPLE);

    // thermometer to binary off the second row
    flaca_decode #(
        .THERMO_W(`FLACA_THERMO_W),
        .RES_W(`FLACA_RES_W)
    ) u_decode (
        .thermo_i(st_ff.row2),
        .code_o(dec_code)
    );

    always_comb begin
        nxt_st = st_ff;

        // two-stage synchronisers for every pin from the analog side
        nxt_st.clk_m = CONV_CLK_I;
        nxt_st.clk_s = st_ff.clk_m;
        nxt_st.phase_m = PHASE_SEL_I;
        nxt_st.phase_s = st_ff.phase_m;
        nxt_st.en_low_m = DATA_ENABLE_LOW_B_I;
        nxt_st.en_low_s = st_ff.en_low_m;
        nxt_st.en_high_m = ALL_ENABLE_HIGH_I;
        nxt_st.en_high_s = st_ff.en_high_m;
        nxt_st.cmp_m = CMP_I;
        nxt_st.cmp_s = st_ff.cmp_m;

        // one balance half and one sample half per clock period
        nxt_st.phase = cur_phase;

        // first row tracks while sampling and is left frozen once balance begins
        if (cur_phase == flaca_pkg::PH_SAMPLE) begin
            nxt_st.row1 = st_ff.cmp_s;
        end

        // second row takes the settled first row when balance ends
        if (smp_start) begin
            nxt_st.row2 = st_ff.row1;
        end

        // the end of the next sample loads the result, hence two like edges of latency
        if (smp_end) begin
            nxt_st.out_reg = dec_code;
            nxt_st.dly = '0;
            nxt_st.dly_run = 1'b1;
            nxt_st.conv_cnt = st_ff.conv_cnt + `FLACA_CNT_W'(1);
        end

        // pins follow the register only after the valid delay; a new load restarts it
        if (st_ff.dly_run && !smp_end) begin
            if (st_ff.dly == `FLACA_DLY_W'(`FLACA_VALID_CYC - 1)) begin
                nxt_st.pin_val = st_ff.out_reg;
                nxt_st.dly_run = 1'b0;
            end else begin
                nxt_st.dly = st_ff.dly + `FLACA_DLY_W'(1);
            end
        end

        // sample length watch, saturating so a parked clock cannot wrap it
        if (cur_phase == flaca_pkg::PH_SAMPLE) begin
            if (st_ff.smp_cnt != `FLACA_SMP_W'(`FLACA_SAMPLE_MAX_CYC)) begin
                nxt_st.smp_cnt = st_ff.smp_cnt + `FLACA_SMP_W'(1);
            end
        end else begin
            nxt_st.smp_cnt = '0;
        end

        // apb: answer is prepared in setup so the access phase needs no wait
        if (apb_setup) begin
            nxt_st.rdata = read_word(apb.addr, st_ff);
            nxt_st.slverr = !reg_hit(apb.addr);
        end
        if (apb_wr && apb.strb[0]) begin
            case (apb.addr)
                `FLACA_REG_CTRL: begin
                    nxt_st.watch_en = apb.wdata[`FLACA_CTRL_WATCH];
                end
                `FLACA_REG_STATUS: begin
                    if (apb.wdata[`FLACA_STAT_OVERRUN]) begin
                        nxt_st.overrun = 1'b0;
                    end
                    if (apb.wdata[`FLACA_STAT_FRESH]) begin
                        nxt_st.fresh = 1'b0;
                    end
                end
                default: begin
                    nxt_st.conv_cnt = nxt_st.conv_cnt;
                end
            endcase
        end

        // hardware sets come last so a set in the clearing cycle wins
        if (st_ff.watch_en && (cur_phase == flaca_pkg::PH_SAMPLE) &&
            (st_ff.smp_cnt == `FLACA_SMP_W'(`FLACA_SAMPLE_MAX_CYC))) begin
            nxt_st.overrun = 1'b1;
        end
        if (smp_end) begin
            nxt_st.fresh = 1'b1;
        end
    end

    // ce low freezes everything, synchronisers included
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            st_ff <= '0;
            st_ff.watch_en <= `FLACA_CTRL_WATCH_RST;
        end else if (CE_I) begin
            st_ff <= nxt_st;
        end
    end

    // three-state drivers: low enable gates data only, high enable gates both
    always_comb begin
        pads.data = st_ff.pin_val[`FLACA_DATA_W-1:0];
        pads.ovr = st_ff.pin_val[`FLACA_RES_W-1];
        pads.data_oe = {`FLACA_DATA_W{st_ff.en_high_s && !st_ff.en_low_s}};
        pads.ovr_oe = st_ff.en_high_s;
    end

    assign SAMPLE_DATA_BITS_O = pads.data;
    assign SAMPLE_DATA_BITS_OE_O = pads.data_oe;
    assign OVER_RANGE_FLAG_O = pads.ovr;
    assign OVER_RANGE_FLAG_OE_O = pads.ovr_oe;
    assign PRDATA_O = st_ff.rdata;
    assign PSLVERR_O = st_ff.slverr;
    assign PREADY_O = 1'b1; // zero wait states, data was fetched in setup

endmodule

// [test/flaca_conv_props.sv]
module flaca_conv_props (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CONV_CLK_I,
    input wire logic PHASE_SEL_I,
    input wire logic DATA_ENABLE_LOW_B_I,
    input wire logic ALL_ENABLE_HIGH_I,
    input wire logic [7:0] SAMPLE_DATA_BITS_O,
    input wire logic [7:0] SAMPLE_DATA_BITS_OE_O,
    input wire logic OVER_RANGE_FLAG_O,
    input wire logic OVER_RANGE_FLAG_OE_O
);
    timeunit 1ns;
    timeprecision 1ns;
    logic smp_ff;
    logic [3:0] since_ff;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // cycles since a sample ended at the pins, saturating so idle never wraps
    always_ff @(posedge CLK_I) begin
        smp_ff <= CONV_CLK_I ^ PHASE_SEL_I;
        if (!RST_B_I) since_ff <= 4'hf;
        else if (smp_ff && !(CONV_CLK_I ^ PHASE_SEL_I)) since_ff <= 4'h0;
        else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
    end
    a_ready_high: assert property (PREADY_O) else $error("pready low");
    a_err_unmapped: assert property (PSEL_I && PENABLE_I && $past(CE_I) |->
        PSLVERR_O == !(PADDR_I inside {12'h000, 12'h004, 12'h008, 12'h00c}))
        else $error("pslverr wrong");
    a_data_on: assert property (
        (CE_I && ALL_ENABLE_HIGH_I && !DATA_ENABLE_LOW_B_I)[*3] |->
        SAMPLE_DATA_BITS_OE_O == 8'hff && OVER_RANGE_FLAG_OE_O) else $error("data not driven");
    a_low_float: assert property (
        (CE_I && DATA_ENABLE_LOW_B_I)[*3] |-> SAMPLE_DATA_BITS_OE_O == 8'h00)
        else $error("data driven while low enable off");
    a_flag_on: assert property (
        (CE_I && ALL_ENABLE_HIGH_I)[*3] |-> OVER_RANGE_FLAG_OE_O) else $error("flag floated");
    a_high_float: assert property (
        (CE_I && !ALL_ENABLE_HIGH_I)[*3] |-> !OVER_RANGE_FLAG_OE_O &&
        SAMPLE_DATA_BITS_OE_O == 8'h00) else $error("driven while high enable off");
    a_over_all: assert property (
        OVER_RANGE_FLAG_O |-> SAMPLE_DATA_BITS_O == 8'hff) else $error("over range not 511");
    a_pins_timed: assert property (
        $changed({OVER_RANGE_FLAG_O, SAMPLE_DATA_BITS_O}) |-> since_ff inside {[4'h5:4'hb]})
        else $error("pins changed away from a capture");
endmodule

bind flaca_conv flaca_conv_props u_props (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .CONV_CLK_I(CONV_CLK_I), .PHASE_SEL_I(PHASE_SEL_I),
    .DATA_ENABLE_LOW_B_I(DATA_ENABLE_LOW_B_I), .ALL_ENABLE_HIGH_I(ALL_ENABLE_HIGH_I),
    .SAMPLE_DATA_BITS_O(SAMPLE_DATA_BITS_O), .SAMPLE_DATA_BITS_OE_O(SAMPLE_DATA_BITS_OE_O),
    .OVER_RANGE_FLAG_O(OVER_RANGE_FLAG_O), .OVER_RANGE_FLAG_OE_O(OVER_RANGE_FLAG_OE_O));

// [test/flaca_host_model.sv]
module flaca_host_model #(
    parameter int HALF = 10
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic phase_sel_i,
    input wire logic pulse_i,
    input wire logic park_i,
    output logic conv_clk_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] cnt_ff;
    // one pulse is a sample half then a balance half, short of the droop limit
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) cnt_ff <= 7'h0;
        else if (cnt_ff == 7'h0) cnt_ff <= pulse_i ? 7'(2 * HALF) : 7'h0;
        else cnt_ff <= cnt_ff - 7'h1;
    end
    // idle parks at the balance level, so standby may last any time
    assign busy_o = cnt_ff != 7'h0;
    // park_i holds the sample level on purpose, only to provoke the droop watch
    assign conv_clk_o = phase_sel_i ^ ((cnt_ff > 7'(HALF)) || park_i);
endmodule

// [test/test_flash_adc_conversion_timing.sv]
module test_flash_adc_conversion_timing;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [255:0] cmp = '0;
    logic phase = 1'b0;
    logic low_b = 1'b0;
    logic high = 1'b1;
    logic pulse = 1'b0;
    logic park = 1'b0;
    logic ce = 1'b1;
    logic conv_clk, busy, pready, pslverr, flag, flag_oe, err;
    logic [31:0] prdata, rd;
    logic [7:0] data, data_oe;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int k_tab [5] = '{0, 1, 128, 255, 256};
    logic [8:0] e_tab [5] = '{9'h000, 9'h001, 9'h080, 9'h0ff, 9'h1ff};
    always #5 clk = ~clk;
    flaca_conv uut (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PSTRB_I(4'h1), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .CONV_CLK_I(conv_clk), .PHASE_SEL_I(phase), .DATA_ENABLE_LOW_B_I(low_b),
        .ALL_ENABLE_HIGH_I(high), .CMP_I(cmp), .SAMPLE_DATA_BITS_O(data),
        .SAMPLE_DATA_BITS_OE_O(data_oe), .OVER_RANGE_FLAG_O(flag), .OVER_RANGE_FLAG_OE_O(flag_oe));
    flaca_host_model #(.HALF(10)) u_host (.clk_i(clk), .rst_b_i(rst_b), .phase_sel_i(phase),
        .pulse_i(pulse), .park_i(park), .conv_clk_o(conv_clk), .busy_o(busy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // setup, then access held until pready; an idle edge keeps drives apart
    task automatic apb(input logic wr, input logic [11:0] a, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // n whole conversion pulses, then settle time for the pins
    task automatic conv(input int n);
        repeat (n) begin
            while (busy !== 1'b0) @(posedge clk);
            pulse <= 1'b1;
            @(posedge clk);
            pulse <= 1'b0;
            @(posedge clk);
        end
        while (busy !== 1'b0) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // cut a hang short; the run needs far fewer cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h000, rd);
        chk(rd, 32'h1);
        apb(1'b1, 12'h000, rd);
        apb(1'b0, 12'h000, rd);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, rd);
        chk({rd[30:0], err}, 32'h1);
        // table rows: thermometer depth against expected code
        for (int r = 0; r < 5; r++) begin
            cmp <= {256{1'b1}} >> (256 - k_tab[r]);
            conv(2);
            chk({flag, data}, e_tab[r]);
            apb(1'b0, 12'h008, rd);
            chk(rd, e_tab[r]);
        end
        // a single pulse must not yet show the new sample
        cmp <= {256{1'b1}} >> 1;
        conv(1);
        chk({flag, data}, 9'h1ff);
        conv(1);
        chk({flag, data}, 9'h0ff);
        // both polarities: sampling level and a full conversion
        for (int ph = 1; ph >= 0; ph--) begin
            phase <= ph[0];
            cmp <= {256{1'b1}} >> (256 - k_tab[ph + 1]);
            repeat (4) @(posedge clk);
            apb(1'b0, 12'h004, rd);
            chk(rd & 32'h4, 32'h0);
            pulse <= 1'b1;
            @(posedge clk);
            pulse <= 1'b0;
            repeat (4) @(posedge clk);
            apb(1'b0, 12'h004, rd);
            chk(rd & 32'h4, 32'h4);
            conv(2);
            chk({flag, data}, e_tab[ph + 1]);
        end
        // every enable combination
        for (int i = 0; i < 4; i++) begin
            {high, low_b} <= i[1:0];
            repeat (4) @(posedge clk);
            chk(data_oe, (i == 2) ? 32'hff : 32'h0);
            chk(flag_oe, i[1]);
        end
        // eighteen loads so far; fresh set by the last one, cleared by writing one
        apb(1'b0, 12'h00c, rd);
        chk(rd, 32'h12);
        apb(1'b0, 12'h004, rd);
        chk(rd & 32'h2, 32'h2);
        pwdata <= 32'h2;
        apb(1'b1, 12'h004, rd);
        apb(1'b0, 12'h004, rd);
        chk(rd & 32'h2, 32'h0);
        // a sample held past the droop limit is flagged while watching
        pwdata <= 32'h1;
        apb(1'b1, 12'h000, rd);
        park <= 1'b1;
        repeat (60) @(posedge clk);
        park <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b0, 12'h004, rd);
        chk(rd & 32'h1, 32'h1);
        // clock enable low freezes everything, so a whole pulse goes uncounted
        ce <= 1'b0;
        conv(1);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, 12'h00c, rd);
        chk(rd, 32'h13);
        wrap_up;
    end
endmodule
